// File: core/dslp_pkg.sv
package dslp_pkg;
    // register word addresses (byte address = 4 * index)
    localparam logic [2:0]  IDX_MEM_POWER    = 3'h0;
    localparam logic [2:0]  IDX_TABLE_RESET  = 3'h1;
    localparam logic [2:0]  IDX_CFG_ONE      = 3'h2;
    localparam logic [2:0]  IDX_CFG_TWO      = 3'h3;
    localparam logic [2:0]  IDX_SW_PORT      = 3'h4;
    localparam logic [2:0]  IDX_IRQ_STATUS   = 3'h5;
    localparam logic [2:0]  IDX_IRQ_MASK     = 3'h6;
    localparam logic [2:0]  IDX_LAST         = 3'h6;

    localparam logic [15:0] RST_MEM_POWER    = 16'h2fff;
    localparam logic [15:0] RST_TABLE_RESET  = 16'hff00;
    localparam logic [15:0] RST_CFG_ONE      = 16'h0000;
    localparam logic [15:0] RST_CFG_TWO      = 16'h0000;
    localparam logic [15:0] RST_SW_PORT      = 16'h0000;

    // memory power fields
    localparam int MP_HOLD_SMBUS  = 4;
    localparam int MP_MASK_OEM    = 12;
    // table reset configuration
    localparam int TR_MTA_PG      = 1;
    // config one fields
    localparam int C1_START       = 0;
    localparam int C1_DIRECT      = 1;
    localparam int C1_WAKE_IND    = 2;
    localparam int C1_STICKY      = 4;
    localparam int C1_INBAND      = 5;
    localparam int C1_WAKE_HOST   = 6;
    localparam int C1_WAKE_MGMT   = 7;
    localparam int C1_DEF_SIDE    = 8;
    localparam int C1_GIG_SIDE    = 9;
    localparam int C1_SLEEP_LAN   = 10;
    localparam int C1_FORCE       = 14;
    localparam int C1_CLR_IND     = 15;
    // config two
    localparam int C2_SHADOW_W    = 5;
    // software port fields
    localparam int SP_SEL_LSB     = 0;
    localparam int SP_SEL_W       = 4;
    localparam int SP_WSTROBE     = 4;
    localparam int SP_WSOURCE     = 5;
    localparam int SP_RSTROBE     = 6;
    localparam int SP_MBOX_LSB    = 8;
    localparam int SP_MBOX_W      = 8;
    // interrupt status bits
    localparam int IRQ_SEQ_DONE   = 0;
    localparam int IRQ_WAKE       = 1;
    localparam int IRQ_PORT_DONE  = 2;
    localparam int IRQ_W          = 3;

    localparam int AUTO_SEQ_CYCLES = 16;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_RUN  = 2'b01,
        SEQ_DONE = 2'b10
    } seq_state_e;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ao_req_s;
endpackage

// File: core/deep_sleep_config_sw_control.sv
`timescale 1ns/1ps
// Overview of operation
// (R1) writing start bit 0 runs auto configuration sequence; hardware clears it when done
// (R2) read strobe bit 6 captures selected bus into mailbox 15:8, then clears
// (R3) write-source bit 5 picks mailbox or default data; cleared after its write
// (R4) write strobe bit 4 issues one write pulse; cleared once issued
// (R5) selector bits 3:0 choose the internal bus address for port accesses
// (R6) mailbox 15:8 resets to zero and is freely read and written
// (R7) sticky bit 4 sleeps on disconnect; wakes if mgmt or host wake set; ENTER_DEEP_SLEEP does not use bits 6,7 and falls when disconnect drops
// (R8) bit 8 makes sideband the default interface after power-on or exit
// (R9) bits 6,7 signal host/mgmt wake on exit; bit 5 selects in-band exit
// (R10) bit 10 lets the lan disable input cause deep-sleep entry
// (R11) bit 9 permits gigabit operation while in sideband mode
// (R12) force bit 14 drives the phy into energy power-down
// (R13) wake indication bit 2 set on wake, cleared by writing one to bit 15
// (R14) direct access bit 1 grants software access to the always-on block
// (R15) bit 1 makes multicast table reset only on power-good
// (R16) bit 4, default one, holds sideband interface on device reset
// (R17) bit 12 masks gigabit-disable and restart-autoneg impact
// (R18) five-bit shadow field 4:0 holds management supply configuration, reset zero
// (R19) one bus transaction per strobe; new strobe ignored until hardware clears
module deep_sleep_config_sw_control
    import dslp_pkg::*;
#(
    parameter int SEQ_CYCLES = AUTO_SEQ_CYCLES
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RESET,
    input  wire logic [4:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        LINK_DISCONNECT,
    input  wire logic        LAN_DISABLE_INPUT,
    input  wire logic        WAKE_EVENT,
    input  wire logic [7:0]  AO_READ_DATA,
    input  wire logic [7:0]  AO_DEFAULT_DATA,
    output ao_req_s          AO_REQ,
    output logic             PORT_WRITE_PULSE,
    output logic             DIRECT_BLOCK_ACCESS,
    output logic             SEQ_BUSY,
    output logic             ENTER_DEEP_SLEEP,
    output logic             FORCE_POWER_DOWN,
    output logic             WAKE_HOST,
    output logic             WAKE_MGMT,
    output logic             INBAND_EXIT,
    output logic             DEFAULT_SIDEBAND,
    output logic             GIGABIT_IN_SIDEBAND,
    output logic             HOLD_SMBUS_ON_DEVICE_RESET,
    output logic             MULTICAST_TABLE_POWERGOOD_RESET,
    output logic             MASK_OEM_BITS,
    output logic [4:0]       MGMT_SUPPLY_SHADOW,
    output logic             IRQ
);
    logic [15:0]       mem_power;
    logic [15:0]       table_reset;
    logic [15:0]       cfg_one;
    logic [15:0]       cfg_two;
    logic [15:0]       sw_port;
    logic [IRQ_W-1:0]  irq_status;
    logic [IRQ_W-1:0]  irq_mask;
    logic [1:0]        lan_sync;
    logic [1:0]        disc_sync;
    logic [1:0]        wake_sync;
    logic              wake_seen;
    logic              ack;
    logic              wr_acc;
    logic              rd_acc;
    logic [2:0]        idx;
    logic              mapped;
    logic [15:0]       wmask;
    logic [15:0]       wval;
    logic              port_rd_go;
    logic              port_wr_go;
    logic              wake_rise;
    logic              seq_done;
    logic [IRQ_W-1:0]  irq_events;
    logic [15:0]       seq_cnt;
    logic [15:0]       busy_len;
    seq_state_e        seq_state;

    // every check in this module runs on the core clock and rests during reset
    default clocking cb_core @(posedge CORE_CLK);
    endclocking
    default disable iff (RESET);

    // one wait state: waitrequest is high in the first cycle of every request
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack;
    assign idx     = AVS_ADDRESS[4:2];
    assign mapped  = (AVS_ADDRESS[1:0] == 2'h0) && (idx <= IDX_LAST);
    assign wr_acc  = AVS_WRITE & ack & mapped;
    // read data are registered in the wait cycle so they stand when the master takes them
    assign rd_acc  = AVS_READ & ~ack;
    assign wmask   = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
    assign wval    = AVS_WRITEDATA[15:0];

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            ack <= 1'b0;
        end else begin
            ack <= (AVS_READ | AVS_WRITE) & ~ack;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            lan_sync  <= 2'h0;
            disc_sync <= 2'h0;
            wake_sync <= 2'h0;
            wake_seen <= 1'b0;
        end else begin
            lan_sync  <= {lan_sync[0], LAN_DISABLE_INPUT};
            disc_sync <= {disc_sync[0], LINK_DISCONNECT};
            wake_sync <= {wake_sync[0], WAKE_EVENT};
            wake_seen <= wake_sync[1];
        end
    end
    assign wake_rise = wake_sync[1] & ~wake_seen;

    // plain control registers; reserved bits outside irq_mask hold whatever software writes
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            mem_power   <= RST_MEM_POWER;
            table_reset <= RST_TABLE_RESET;
            cfg_two     <= RST_CFG_TWO;
            irq_mask    <= '0;
        end else if (wr_acc) begin
            case (idx)
                IDX_MEM_POWER:   mem_power   <= (mem_power & ~wmask) | (wval & wmask);
                IDX_TABLE_RESET: table_reset <= (table_reset & ~wmask) | (wval & wmask);
                IDX_CFG_TWO:     cfg_two     <= (cfg_two & ~wmask) | (wval & wmask); // (R18)
                IDX_IRQ_MASK:    irq_mask    <= AVS_BYTEENABLE[0] ? wval[IRQ_W-1:0] : irq_mask;
                default: begin
                end
            endcase
        end
    end

    // auto configuration sequence: fixed-length walk, then start self-clears
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            seq_state <= SEQ_IDLE;
            seq_cnt   <= '0;
        end else begin
            case (seq_state)
                SEQ_IDLE: begin
                    if (cfg_one[C1_START]) begin // (R1)
                        seq_state <= SEQ_RUN;
                        seq_cnt   <= 16'(SEQ_CYCLES - 1);
                    end
                end
                SEQ_RUN: begin
                    if (seq_cnt == 16'h0) begin
                        seq_state <= SEQ_DONE;
                    end else begin
                        seq_cnt <= seq_cnt - 16'h1;
                    end
                end
                SEQ_DONE: seq_state <= SEQ_IDLE;
                default:  seq_state <= SEQ_IDLE;
            endcase
        end
    end
    assign seq_done = (seq_state == SEQ_DONE);
    assign SEQ_BUSY = (seq_state != SEQ_IDLE);

    // helper for the checks: cycles spent busy in the current run
    always_ff @(posedge CORE_CLK) begin
        if (RESET || !SEQ_BUSY) begin
            busy_len <= '0;
        end else begin
            busy_len <= busy_len + 16'h1;
        end
    end

    // wake indication: a wake landing as the clear bit acts, one cycle after the clear write, still sets the bit
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            cfg_one <= RST_CFG_ONE;
        end else begin
            if (wr_acc && idx == IDX_CFG_ONE) begin
                if (AVS_BYTEENABLE[0]) begin
                    // start cannot be dropped by software while the sequence runs
                    cfg_one[7:0] <= {wval[7:1], wval[C1_START] | cfg_one[C1_START]};
                end
                if (AVS_BYTEENABLE[1]) begin
                    cfg_one[15:8] <= wval[15:8];
                end
            end
            if (seq_done) begin
                cfg_one[C1_START] <= 1'b0; // (R1)
            end
            if (cfg_one[C1_CLR_IND]) begin
                cfg_one[C1_WAKE_IND] <= 1'b0; // (R13)
                cfg_one[C1_CLR_IND]  <= 1'b0;
            end
            if (wake_rise) begin
                cfg_one[C1_WAKE_IND] <= 1'b1; // (R13)
            end
        end
    end

    // software port: strobes act once, then hardware clears them
    assign port_rd_go = sw_port[SP_RSTROBE]; // (R19)
    assign port_wr_go = sw_port[SP_WSTROBE] & ~sw_port[SP_RSTROBE];

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            sw_port <= RST_SW_PORT; // (R6)
        end else begin
            if (wr_acc && idx == IDX_SW_PORT) begin
                if (AVS_BYTEENABLE[1]) begin
                    sw_port[15:8] <= wval[15:8]; // (R6)
                end
                if (AVS_BYTEENABLE[0]) begin
                    sw_port[3:0] <= wval[3:0]; // (R5)
                    sw_port[7]   <= wval[7];
                    // a strobe already pending is not restarted
                    sw_port[SP_RSTROBE] <= sw_port[SP_RSTROBE] | wval[SP_RSTROBE]; // (R19)
                    sw_port[SP_WSTROBE] <= sw_port[SP_WSTROBE] | wval[SP_WSTROBE];
                    sw_port[SP_WSOURCE] <= sw_port[SP_WSTROBE] ? sw_port[SP_WSOURCE] : wval[SP_WSOURCE];
                end
            end
            if (port_rd_go) begin
                sw_port[15:8]       <= AO_READ_DATA; // (R2)
                sw_port[SP_RSTROBE] <= 1'b0;
            end else if (port_wr_go) begin
                sw_port[SP_WSTROBE] <= 1'b0; // (R4)
                sw_port[SP_WSOURCE] <= 1'b0; // (R3)
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            AO_REQ           <= '0;
            PORT_WRITE_PULSE <= 1'b0;
        end else begin
            AO_REQ.addr      <= sw_port[SP_SEL_W-1:0]; // (R5)
            AO_REQ.rd        <= port_rd_go;
            AO_REQ.wr        <= port_wr_go; // (R4)
            PORT_WRITE_PULSE <= port_wr_go; // (R19)
            AO_REQ.wdata     <= sw_port[SP_WSOURCE] ? sw_port[15:8] : AO_DEFAULT_DATA; // (R3)
        end
    end

    // interrupt status, write one to clear; a new event beats the clear
    assign irq_events = {port_rd_go | port_wr_go, wake_rise, seq_done};
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            irq_status <= '0;
        end else begin
            if (wr_acc && idx == IDX_IRQ_STATUS && AVS_BYTEENABLE[0]) begin
                irq_status <= (irq_status & ~wval[IRQ_W-1:0]) | irq_events;
            end else begin
                irq_status <= irq_status | irq_events;
            end
        end
    end
    assign IRQ = |(irq_status & irq_mask);

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            AVS_READDATA <= '0;
        end else if (rd_acc) begin
            case (AVS_ADDRESS)
                {IDX_MEM_POWER, 2'h0}:   AVS_READDATA <= {16'h0, mem_power};
                {IDX_TABLE_RESET, 2'h0}: AVS_READDATA <= {16'h0, table_reset};
                {IDX_CFG_ONE, 2'h0}:     AVS_READDATA <= {16'h0, cfg_one};
                {IDX_CFG_TWO, 2'h0}:     AVS_READDATA <= {16'h0, cfg_two};
                {IDX_SW_PORT, 2'h0}:     AVS_READDATA <= {16'h0, sw_port};
                {IDX_IRQ_STATUS, 2'h0}:  AVS_READDATA <= {29'h0, irq_status};
                {IDX_IRQ_MASK, 2'h0}:    AVS_READDATA <= {29'h0, irq_mask};
                default:                 AVS_READDATA <= 32'h0;
            endcase
        end
    end

    // the sequence itself reuses the same always-on controls; sleep entry waits for it
    assign ENTER_DEEP_SLEEP = ~SEQ_BUSY &
                              ((cfg_one[C1_STICKY] & disc_sync[1]) | // (R7)
                               (cfg_one[C1_SLEEP_LAN] & lan_sync[1])); // (R10)
    assign FORCE_POWER_DOWN    = cfg_one[C1_FORCE]; // (R12)
    assign WAKE_HOST           = cfg_one[C1_WAKE_HOST]; // (R9)
    assign WAKE_MGMT           = cfg_one[C1_WAKE_MGMT]; // (R9)
    assign INBAND_EXIT         = cfg_one[C1_INBAND]; // (R9)
    assign DEFAULT_SIDEBAND    = cfg_one[C1_DEF_SIDE]; // (R8)
    assign GIGABIT_IN_SIDEBAND = cfg_one[C1_GIG_SIDE]; // (R11)
    assign DIRECT_BLOCK_ACCESS = cfg_one[C1_DIRECT]; // (R14)
    assign HOLD_SMBUS_ON_DEVICE_RESET      = mem_power[MP_HOLD_SMBUS]; // (R16)
    assign MULTICAST_TABLE_POWERGOOD_RESET = table_reset[TR_MTA_PG]; // (R15)
    assign MASK_OEM_BITS       = mem_power[MP_MASK_OEM]; // (R17)
    assign MGMT_SUPPLY_SHADOW  = cfg_two[C2_SHADOW_W-1:0]; // (R18)

    // auto sequence: start self-clears only after the full walk
    a_start_clears: assert property (seq_done |=> !cfg_one[C1_START]) // (R1)
        else $error("start bit not cleared after sequence");

    a_start_runs: assert property (!SEQ_BUSY && cfg_one[C1_START] |=> SEQ_BUSY) // (R1)
        else $error("sequence did not start");

    a_seq_length: assert property (seq_done |-> busy_len == 16'(SEQ_CYCLES)) // (R1)
        else $error("sequence length wrong");

    // software port: each strobe yields exactly one request
    sequence s_rd_issue;
        port_rd_go ##1 AO_REQ.rd;
    endsequence

    sequence s_wr_issue;
        port_wr_go ##1 PORT_WRITE_PULSE;
    endsequence

    a_read_capture: assert property (port_rd_go |=> sw_port[15:8] == $past(AO_READ_DATA) && AO_REQ.rd) // (R2)
        else $error("read strobe did not capture bus data");

    a_read_clears: assert property (s_rd_issue |-> !sw_port[SP_RSTROBE]) // (R2)
        else $error("read strobe not cleared");

    a_write_source: assert property (port_wr_go && sw_port[SP_WSOURCE] |=> AO_REQ.wdata == $past(sw_port[15:8])) // (R3)
        else $error("write data not from mailbox");

    a_write_default: assert property (port_wr_go && !sw_port[SP_WSOURCE] |=> AO_REQ.wdata == $past(AO_DEFAULT_DATA)) // (R3)
        else $error("write data not from default bus");

    a_source_clears: assert property (s_wr_issue |-> !sw_port[SP_WSOURCE]) // (R3)
        else $error("write source not cleared");

    a_write_once: assert property (s_wr_issue |-> !sw_port[SP_WSTROBE] ##1 !PORT_WRITE_PULSE) // (R4)
        else $error("write strobe issued more than once");

    a_pulse_pairs: assert property (PORT_WRITE_PULSE == AO_REQ.wr) // (R4)
        else $error("write pulse apart from request");

    a_sel_addr: assert property (port_rd_go || port_wr_go |=> AO_REQ.addr == $past(sw_port[3:0])) // (R5)
        else $error("bus address does not follow selector");

    a_mailbox_hold: assert property (!port_rd_go && !(wr_acc && idx == IDX_SW_PORT) |=> $stable(sw_port[15:8])) // (R6)
        else $error("mailbox changed without cause");

    a_req_single: assert property (AO_REQ.rd |-> !AO_REQ.wr) // (R19)
        else $error("read and write issued together");

    // wake indication and sleep entry
    a_wake_ind: assert property (wake_rise |=> cfg_one[C1_WAKE_IND]) // (R13)
        else $error("wake indication not set");

    a_ind_clear: assert property (cfg_one[C1_CLR_IND] && !wake_rise |=> !cfg_one[C1_WAKE_IND] && !cfg_one[C1_CLR_IND]) // (R13)
        else $error("wake indication not cleared");

    a_sleep_lan: assert property (!cfg_one[C1_SLEEP_LAN] && !cfg_one[C1_STICKY] |-> !ENTER_DEEP_SLEEP) // (R10)
        else $error("sleep entered without enable");

    a_sleep_lan_on: assert property (cfg_one[C1_SLEEP_LAN] && lan_sync[1] && !SEQ_BUSY |-> ENTER_DEEP_SLEEP) // (R10)
        else $error("lan disable did not enter sleep");

    a_sleep_disc: assert property (cfg_one[C1_STICKY] && disc_sync[1] && !SEQ_BUSY |-> ENTER_DEEP_SLEEP) // (R7)
        else $error("disconnect did not enter sleep");

    // interrupts: status is sticky, the level follows the mask
    a_irq_seq: assert property (seq_done |=> irq_status[IRQ_SEQ_DONE])
        else $error("sequence status not set");

    a_irq_wake: assert property (wake_rise |=> irq_status[IRQ_WAKE])
        else $error("wake status not set");

    a_irq_level: assert property (IRQ == |(irq_status & irq_mask))
        else $error("interrupt level wrong");
endmodule

// File: test/deep_sleep_config_sw_control_test.sv
`timescale 1ns/1ps
module deep_sleep_config_sw_control_test;
    import dslp_pkg::*;
    localparam int          SEQ_N = 4;
    localparam logic [15:0] RMASK [5] = '{16'h1010, 16'hffff, 16'hffff, 16'h001f, 16'hff7f};
    localparam logic [15:0] REXP  [5] = '{16'h0010, 16'hff00, 16'h0000, 16'h0000, 16'h0000};
    logic        core_clk;
    logic        reset;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        link_disc;
    logic        lan_dis;
    logic        wake_event;
    logic [7:0]  ao_rd;
    logic [7:0]  ao_def;
    ao_req_s     ao_req;
    ao_req_s     last_req;
    logic        wpulse;
    logic [6:0]  lvl;
    logic [2:0]  misc;
    logic        seq_busy;
    logic        enter_sleep;
    logic        irq;
    logic [4:0]  shadow;
    logic [31:0] q;
    logic [15:0] c;
    logic [15:0] m;
    logic [15:0] t;
    logic [3:0]  sel;
    logic [7:0]  mb;
    int          err_count;
    int          checks_done;
    int          req_count;
    int          seed;
    int          cnt0;
    logic [15:0] sleep_tab [5] = '{16'h0010, 16'h0400, 16'h0000, 16'h0010, 16'h0400};
    logic [2:0]  sleep_in  [5] = '{3'b101, 3'b011, 3'b110, 3'b010, 3'b100};

    deep_sleep_config_sw_control #(.SEQ_CYCLES(SEQ_N)) dut_u (
        .CORE_CLK(core_clk), .RESET(reset), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
        .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hf),
        .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .LINK_DISCONNECT(link_disc),
        .LAN_DISABLE_INPUT(lan_dis), .WAKE_EVENT(wake_event), .AO_READ_DATA(ao_rd), .AO_DEFAULT_DATA(ao_def),
        .AO_REQ(ao_req), .PORT_WRITE_PULSE(wpulse), .DIRECT_BLOCK_ACCESS(lvl[6]), .SEQ_BUSY(seq_busy),
        .ENTER_DEEP_SLEEP(enter_sleep), .FORCE_POWER_DOWN(lvl[0]), .WAKE_HOST(lvl[4]), .WAKE_MGMT(lvl[3]),
        .INBAND_EXIT(lvl[5]), .DEFAULT_SIDEBAND(lvl[2]), .GIGABIT_IN_SIDEBAND(lvl[1]),
        .HOLD_SMBUS_ON_DEVICE_RESET(misc[2]), .MULTICAST_TABLE_POWERGOOD_RESET(misc[0]),
        .MASK_OEM_BITS(misc[1]), .MGMT_SUPPLY_SHADOW(shadow), .IRQ(irq));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // waitrequest is read at the rising edge, before that edge's updates land
    task automatic wait_ack;
        int k;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        if (avs_waitrequest !== 1'b0) begin
            check("bus answer", 1, 0);
            finish_test();
        end
    endtask

    task automatic bus_write(input logic [2:0] idx, input logic [15:0] d);
        @(posedge core_clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {16'h0000, d};
        avs_write <= 1'b1;
        wait_ack();
        avs_write <= 1'b0;
    endtask

    // read data are taken at the edge that ends the request
    task automatic bus_read(input logic [2:0] idx, output logic [31:0] r);
        @(posedge core_clk);
        avs_address <= {idx, 2'b00};
        avs_read <= 1'b1;
        wait_ack();
        r = avs_readdata;
        avs_read <= 1'b0;
    endtask

    task automatic poll(input logic [2:0] idx, input int b, input logic val);
        logic [31:0] r;
        int k;
        k = 0;
        do begin
            bus_read(idx, r);
            k++;
        end while (r[b] !== val && k < 40);
        check("polled bit", r[b], val);
    endtask

    function automatic logic [15:0] port_expect(int mode, logic [3:0] s, logic [7:0] mbox, logic [7:0] rv);
        return {(mode == 0) ? rv : mbox, 4'h0, s};
    endfunction

    always @(posedge core_clk) begin
        if (ao_req.wr === 1'b1 || ao_req.rd === 1'b1) begin
            req_count++;
            last_req = ao_req;
        end
        if (wpulse !== ao_req.wr) check("write pulse", wpulse, ao_req.wr);
    end

    initial begin
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        {link_disc, lan_dis, wake_event, ao_rd, ao_def} = '0;
        {err_count, checks_done, req_count} = '0;
        seed = 85167;
        reset = 1'b1;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        @(negedge core_clk);
        check("reset outputs", {misc, lvl, irq, ao_req}, {3'b100, 7'h00, 1'b0, 14'h0});
        for (int i = 0; i < 5; i++) begin
            bus_read(3'(i), q);
            check("reset value", q[15:0] & RMASK[i], REXP[i]);
        end
        for (int i = 0; i < 8; i++) begin
            c = 16'($random(seed)) & 16'h47f2;
            m = 16'($random(seed));
            t = 16'($random(seed));
            bus_write(IDX_CFG_ONE, c);
            bus_write(IDX_MEM_POWER, m);
            bus_write(IDX_TABLE_RESET, t);
            bus_write(IDX_CFG_TWO, t ^ m);
            @(negedge core_clk);
            check("levels", lvl, {c[1], c[5], c[6], c[7], c[8], c[9], c[14]});
            check("misc levels", misc, {m[4], m[12], t[1]});
            check("shadow", shadow, 5'(t ^ m));
            bus_read(IDX_CFG_ONE, q);
            check("config one", q, {16'h0, c});
            bus_write(IDX_SW_PORT, m & 16'hff0f);
            bus_read(IDX_SW_PORT, q);
            check("mailbox", q[15:0] & 16'hff0f, m & 16'hff0f);
        end
        for (int i = 0; i < 5; i++) begin
            bus_write(IDX_CFG_ONE, sleep_tab[i]);
            @(posedge core_clk);
            {link_disc, lan_dis} <= sleep_in[i][2:1];
            // full synchroniser delay, so a wrong entry has time to show
            repeat (4) @(negedge core_clk);
            check("sleep entry", enter_sleep, sleep_in[i][0]);
            @(posedge core_clk);
            {link_disc, lan_dis} <= 2'b00;
            repeat (6) @(posedge core_clk);
        end
        bus_write(IDX_CFG_ONE, 16'h0000);
        bus_write(IDX_IRQ_MASK, 16'h0000);
        bus_write(IDX_IRQ_STATUS, 16'h0007);
        bus_write(IDX_CFG_ONE, 16'h0001);
        repeat (2) @(negedge core_clk);
        check("sequence busy", seq_busy, 1'b1);
        poll(IDX_CFG_ONE, C1_START, 1'b0);
        bus_read(IDX_IRQ_STATUS, q);
        check("sequence done", {q[IRQ_SEQ_DONE], irq}, 2'b10);
        bus_write(IDX_IRQ_MASK, 16'h0001);
        @(negedge core_clk);
        check("irq raised", irq, 1'b1);
        bus_write(IDX_IRQ_STATUS, 16'h0001);
        @(negedge core_clk);
        check("irq cleared", irq, 1'b0);
        for (int j = 0; j < 9; j++) begin
            sel = 4'($random(seed));
            mb = 8'($random(seed));
            @(posedge core_clk);
            ao_rd <= 8'($random(seed));
            ao_def <= 8'($random(seed));
            bus_write(IDX_SW_PORT, {mb, 4'h0, sel});
            cnt0 = req_count;
            bus_write(IDX_SW_PORT, {mb, 1'b0, 1'(j % 3 == 0), 1'(j % 3 == 1), 1'(j % 3 != 0), sel});
            bus_read(IDX_SW_PORT, q);
            check("port register", q, {16'h0, port_expect(j % 3, sel, mb, ao_rd)});
            check("port requests", req_count - cnt0, 1);
            check("request fields", {last_req.addr, (j % 3 == 0) ? 8'h00 : last_req.wdata, last_req.wr, last_req.rd},
                  {sel, (j % 3 == 1) ? mb : ((j % 3 == 2) ? ao_def : 8'h00), 1'(j % 3 != 0), 1'(j % 3 == 0)});
        end
        bus_read(IDX_IRQ_STATUS, q);
        check("port done", q[IRQ_PORT_DONE], 1'b1);
        @(posedge core_clk);
        wake_event <= 1'b1;
        poll(IDX_CFG_ONE, C1_WAKE_IND, 1'b1);
        bus_read(IDX_IRQ_STATUS, q);
        check("wake status", q[IRQ_WAKE], 1'b1);
        wake_event <= 1'b0;
        bus_write(IDX_CFG_ONE, 16'h8004);
        poll(IDX_CFG_ONE, C1_WAKE_IND, 1'b0);
        bus_read(IDX_CFG_ONE, q);
        check("clear bit", q[C1_CLR_IND], 1'b0);
        bus_read(3'h7, q);
        check("unmapped read", q, 32'h0);
        finish_test();
    end
endmodule
